// [sim/txsc_properties.sv]
// Port checks for the transaction state control block
`timescale 1ns/1ps
`include "txsc_regs.svh"
module txsc_checker (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        op_begin,
    input wire logic        op_begin_rot,
    input wire logic        op_end,
    input wire logic        op_abort,
    input wire logic        op_abort_cond,
    input wire logic        abort_cond_ok,
    input wire logic        op_suspres,
    input wire logic        intr_taken,
    input wire logic        conflict,
    input wire logic        ifetch_ci,
    input wire logic        recovery,
    input wire logic        quiesce,
    input wire logic [1:0]  tx_state,
    input wire logic        commit_pulse,
    input wire logic        discard_pulse,
    input wire logic        restore_pulse,
    input wire logic        redirect_pulse,
    input wire logic        barrier_pulse,
    input wire logic        rot_active,
    input wire logic        atomic_hold,
    input wire logic [15:0] txn_exception_status_reg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // No failure cause and no other state change this cycle
    wire calm = !(op_abort | conflict | ifetch_ci | recovery | quiesce);
    wire quiet = calm && !intr_taken && !op_suspres && !op_end;
    wire in_tx = tx_state == 2'd1;
    // Rollback is one cycle of discard, restore and redirect
    sequence s_fail;
        discard_pulse && restore_pulse && redirect_pulse && tx_state == 2'd0 ##1 !discard_pulse;
    endsequence
    chk_begin_enter:
    assert property (tx_state == 2'd0 && op_begin |=> in_tx && !barrier_pulse)
        else $error("begin did not enter transaction");
    chk_end_commit:
    assert property (in_tx && op_end && calm && !intr_taken && !op_suspres
        |=> commit_pulse && tx_state == 2'd0) else $error("end did not commit");
    chk_abort_fail:
    assert property (in_tx && op_abort && (!op_abort_cond || abort_cond_ok) |=> s_fail)
        else $error("abort did not roll back");
    chk_conflict_fail:
    assert property (in_tx && conflict && !rot_active |=> s_fail) else $error("conflict kept");
    chk_impl_cause:
    assert property ((in_tx && ifetch_ci) || (tx_state != 2'd0 && (recovery || quiesce))
        |=> txn_exception_status_reg[`TXSC_BIT_IMPL] && !txn_exception_status_reg[0])
        else $error("cause bits wrong");
    chk_intr_suspend:
    assert property (in_tx && intr_taken && calm && !op_suspres && !op_end
        |=> tx_state == 2'd2) else $error("interrupt did not suspend");
    chk_suspres_swap:
    assert property (tx_state != 2'd0 && op_suspres && calm && !intr_taken && !op_end
        |=> barrier_pulse && tx_state != 2'd0 && tx_state != $past(tx_state))
        else $error("suspend or resume wrong");
    chk_rot_begin:
    assert property (tx_state == 2'd0 && op_begin
        |=> rot_active == $past(op_begin_rot) && atomic_hold == !$past(op_begin_rot))
        else $error("rollback-only flags wrong");
    chk_cause_kept:
    assert property (tx_state == 2'd0 && !op_begin |=> $stable(txn_exception_status_reg))
        else $error("status changed while idle");
endmodule
bind txsc_top txsc_checker chk_u (.sys_clk, .resetn, .op_begin, .op_begin_rot, .op_end,
    .op_abort, .op_abort_cond, .abort_cond_ok, .op_suspres, .intr_taken, .conflict,
    .ifetch_ci, .recovery, .quiesce, .tx_state, .commit_pulse, .discard_pulse,
    .restore_pulse, .redirect_pulse, .barrier_pulse, .rot_active, .atomic_hold,
    .txn_exception_status_reg);

// [sim/txsc_testbench.sv]
// Self-checking bench for the transaction state control block
`timescale 1ns/1ps
`include "txsc_regs.svh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [11:0] pv = 12'h000;
    logic [63:0] handler_addr = 64'h0;
    logic [63:0] user_reg = 64'h0;
    logic op_begin, op_begin_rot, op_end, op_abort, op_abort_cond, abort_cond_ok;
    logic op_suspres, intr_taken, conflict, ifetch_ci, recovery, quiesce;
    logic [63:0] restore_val, redirect_addr;
    logic [1:0]  tx_state;
    logic [15:0] txn_exception_status_reg;
    logic store_tx_tag, commit_pulse, discard_pulse, restore_pulse, redirect_pulse;
    logic barrier_pulse, rot_active, atomic_hold;
    int n_errors = 0;
    int cmp_count = 0;
    localparam logic [11:0] BEG = 12'h800, RBO = 12'h400, FIN = 12'h200, ABT = 12'h100;
    localparam logic [11:0] ACND = 12'h080, CND = 12'h040, SRS = 12'h020, INT = 12'h010;
    localparam logic [11:0] CFL = 12'h008, IFC = 12'h004, RCV = 12'h002, QSC = 12'h001;
    localparam logic [11:0] IMPL [5] = '{IFC, RCV, QSC, RCV, QSC};
    // Pulse inputs come from one vector
    assign {op_begin, op_begin_rot, op_end, op_abort, op_abort_cond, abort_cond_ok,
        op_suspres, intr_taken, conflict, ifetch_ci, recovery, quiesce} = pv;
    txsc_top dut_u (.sys_clk, .resetn, .op_begin, .op_begin_rot, .handler_addr, .user_reg,
        .op_end, .op_abort, .op_abort_cond, .abort_cond_ok, .op_suspres, .intr_taken,
        .conflict, .ifetch_ci, .recovery, .quiesce, .tx_state, .store_tx_tag, .commit_pulse,
        .discard_pulse, .restore_pulse, .restore_val, .redirect_pulse, .redirect_addr,
        .barrier_pulse, .rot_active, .atomic_hold, .txn_exception_status_reg);
    always #50 sys_clk = ~sys_clk;
    // One cycle of pulses; the answer is settled on return
    task op(input logic [11:0] v);
        @(negedge sys_clk);
        pv = v;
        @(negedge sys_clk);
        pv = 12'h000;
    endtask
    task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Begin then end commits without a barrier at begin
    task t_commit;
        op(BEG);
        chk("state", 2'd1, tx_state);
        chk("tag", 1'b1, store_tx_tag);
        chk("hold", 1'b1, atomic_hold);
        chk("bar", 1'b0, barrier_pulse);
        op(FIN);
        chk("commit", 1'b1, commit_pulse);
        chk("bar", 1'b1, barrier_pulse);
    endtask
    // False conditional abort is ignored; true and plain abort roll back
    task t_abort;
        for (int i = 0; i < 2; i++) begin
            user_reg = 64'h1234_0000_0000_00a0 + i;
            handler_addr = 64'h0000_0000_0000_4000 + i;
            op(BEG);
            user_reg = 64'h0;
            op(ABT | ACND);
            chk("state", 2'd1, tx_state);
            op(i ? (ABT | ACND | CND) : ABT);
            chk("discard", 1'b1, discard_pulse);
            chk("restore", 1'b1, restore_pulse);
            chk("ckpt", 64'h1234_0000_0000_00a0 + i, restore_val);
            chk("target", 64'h0000_0000_0000_4000 + i, redirect_addr);
        end
    endtask
    // Conflict fails a normal transaction but not a rollback-only one
    task t_conflict;
        op(BEG);
        op(CFL);
        chk("discard", 1'b1, discard_pulse);
        op(BEG | RBO);
        chk("rot", 1'b1, rot_active);
        chk("hold", 1'b0, atomic_hold);
        op(CFL);
        chk("state", 2'd1, tx_state);
        op(ABT);
    endtask
    // Interrupt suspends; suspend/resume toggles; end is ignored while suspended
    task t_suspend;
        op(BEG);
        op(INT);
        chk("state", 2'd2, tx_state);
        chk("tag", 1'b0, store_tx_tag);
        op(FIN);
        chk("state", 2'd2, tx_state);
        op(SRS);
        chk("state", 2'd1, tx_state);
        chk("bar", 1'b1, barrier_pulse);
        op(SRS);
        chk("state", 2'd2, tx_state);
        op(QSC);
        chk("state", 2'd0, tx_state);
    endtask
    // Implementation causes in both states, kept until the next begin
    task t_impl;
        for (int i = 0; i < 5; i++) begin
            op(BEG);
            if (i > 2) op(INT);
            op(IMPL[i]);
            chk("fail", 1'b1, redirect_pulse);
            chk("impl", 1'b1, txn_exception_status_reg[`TXSC_BIT_IMPL]);
            chk("persist", 1'b0, txn_exception_status_reg[`TXSC_BIT_PERSIST]);
        end
        op(12'h000);
        chk("kept", 1'b1, txn_exception_status_reg[`TXSC_BIT_IMPL]);
        op(BEG);
        chk("clear", 16'h0000, txn_exception_status_reg);
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        t_commit();
        t_abort();
        t_conflict();
        t_suspend();
        t_impl();
        finish_test();
    end
    // Watchdog
    initial begin
        #200_000;
        n_errors++;
        finish_test();
    end
endmodule

// [src/txsc_fail_cause.sv]
// Failure cause detection and status word composition
`timescale 1ns/1ps
`include "txsc_regs.svh"
module txsc_fail_cause (
    input  wire logic                     in_tx,        // Thread transactional
    input  wire logic                     in_susp,      // Thread suspended
    input  wire logic                     abort_req,    // Abort instruction fired
    input  wire logic                     abort_cond,   // Condition for conditional abort
    input  wire logic                     abort_is_cond,// Abort is the conditional form
    input  wire logic                     conflict,     // Other-thread conflicting access
    input  wire logic                     ifetch_ci,    // Fetch hits caching-inhibited page
    input  wire logic                     recovery,     // Hardware recovery action
    input  wire logic                     quiesce,      // Quiesce request
    input  wire logic                     rollback_only_txn,          // Current txn is rollback-only
    output logic                          fail,         // Transaction fails now
    output logic [`TXSC_TESR_W-1:0]       fail_status   // Status word for this failure
);
    // Each cause qualified by the state in which it applies
    wire active      = in_tx | in_susp;
    wire abort_hit   = in_tx & abort_req & (~abort_is_cond | abort_cond);
    wire confl_hit   = active & conflict & ~rollback_only_txn;
    wire ifetch_hit  = in_tx & ifetch_ci;
    wire recov_hit   = active & recovery;
    wire quies_hit   = active & quiesce;
    wire impl_hit    = ifetch_hit | recov_hit | quies_hit;

    assign fail = abort_hit | confl_hit | impl_hit;

    // Compose status; persistent bit stays zero for implementation causes
    always_comb begin
        fail_status = `TXSC_TESR_RESET;
        fail_status[`TXSC_BIT_IMPL]     = impl_hit;
        fail_status[`TXSC_BIT_PERSIST]  = 1'b0;
        fail_status[`TXSC_BIT_ABORT]    = abort_hit;
        fail_status[`TXSC_BIT_CONFLICT] = confl_hit;
        fail_status[`TXSC_BIT_RBONLY]   = rollback_only_txn;
    end
endmodule

// [src/txsc_pkg.sv]
// Types for the transaction state control block
package txsc_pkg;
    typedef enum logic [1:0] {
        TXSC_NONTX,
        TXSC_TX,
        TXSC_SUSP
    } txsc_state_t;
    typedef enum logic [2:0] {
        TXSC_CAUSE_NONE,
        TXSC_CAUSE_ABORT,
        TXSC_CAUSE_CONFLICT,
        TXSC_CAUSE_IFETCH_CI,
        TXSC_CAUSE_RECOVERY,
        TXSC_CAUSE_QUIESCE
    } txsc_cause_t;
endpackage

// [src/txsc_regs.svh]
// Constants for the transaction state control block
`ifndef TXSC_REGS_SVH
`define TXSC_REGS_SVH
`define TXSC_TESR_W          16
`define TXSC_TESR_RESET      16'h0000
`define TXSC_BIT_PERSIST     0
`define TXSC_BIT_IMPL        15
`define TXSC_BIT_CONFLICT    1
`define TXSC_BIT_ABORT       2
`define TXSC_BIT_INTR        3
`define TXSC_BIT_RBONLY      4
`define TXSC_ADDR_RESET      64'h0000_0000_0000_0000
`endif

// [src/txsc_top.sv]
// Per-thread transaction state control: begin, commit, abort, suspend, rollback
`timescale 1ns/1ps
`include "txsc_regs.svh"
module txsc_top #(
    parameter int REG_W = 64                      // Checkpointed register width
) (
    input  wire logic                   sys_clk,        // Core clock, 10 MHz
    input  wire logic                   resetn,         // Synchronous reset, active low
    input  wire logic                   op_begin,       // Begin instruction executes
    input  wire logic                   op_begin_rot,   // Begin requests rollback-only
    input  wire logic [63:0]            handler_addr,   // Failure handler for this begin
    input  wire logic [REG_W-1:0]       user_reg,       // Live user register state
    input  wire logic                   op_end,         // End instruction executes
    input  wire logic                   op_abort,       // Abort instruction executes
    input  wire logic                   op_abort_cond,  // Abort is conditional form
    input  wire logic                   abort_cond_ok,  // Conditional abort condition holds
    input  wire logic                   op_suspres,     // Suspend/resume instruction
    input  wire logic                   intr_taken,     // Interrupt taken
    input  wire logic                   conflict,       // Conflicting remote access
    input  wire logic                   ifetch_ci,      // Fetch to caching-inhibited page
    input  wire logic                   recovery,       // Hardware recovery action
    input  wire logic                   quiesce,        // Quiesce request
    output logic [1:0]                  tx_state,       // 0 non, 1 transactional, 2 suspended
    output logic                        store_tx_tag,   // Stores now belong to transaction
    output logic                        commit_pulse,   // Publish buffered stores
    output logic                        discard_pulse,  // Drop buffered stores
    output logic                        restore_pulse,  // Load checkpoint into registers
    output logic [REG_W-1:0]            restore_val,    // Checkpointed register value
    output logic                        redirect_pulse, // Redirect fetch
    output logic [63:0]                 redirect_addr,  // Handler target
    output logic                        barrier_pulse,  // Apply memory barrier
    output logic                        rot_active,     // Current txn is rollback-only
    output logic                        atomic_hold,    // Hold off remote observation
    output logic [`TXSC_TESR_W-1:0]     txn_exception_status_reg // Failure status
);
    txsc_pkg::txsc_state_t state;
    txsc_pkg::txsc_state_t next_state;
    logic [63:0]               handler;
    logic [REG_W-1:0]          ckpt;
    logic                      rollback_only_txn;
    logic                      fail;
    logic [`TXSC_TESR_W-1:0]   fail_status;

    // Decode of current state and instruction effects
    wire in_tx     = (state == txsc_pkg::TXSC_TX);
    wire in_susp   = (state == txsc_pkg::TXSC_SUSP);
    wire idle      = (state == txsc_pkg::TXSC_NONTX);
    wire do_begin  = idle & op_begin;
    wire do_end    = in_tx & op_end & ~fail;
    wire do_intr   = in_tx & intr_taken & ~fail;
    wire do_susp   = in_tx & op_suspres & ~fail & ~intr_taken;
    wire do_resume = in_susp & op_suspres & ~fail;

    txsc_fail_cause u_cause (
        .in_tx         (in_tx),
        .in_susp       (in_susp),
        .abort_req     (op_abort),
        .abort_cond    (abort_cond_ok),
        .abort_is_cond (op_abort_cond),
        .conflict      (conflict),
        .ifetch_ci     (ifetch_ci),
        .recovery      (recovery),
        .quiesce       (quiesce),
        .rollback_only_txn           (rollback_only_txn),
        .fail          (fail),
        .fail_status   (fail_status)
    );

    // Next state selection; failure outranks every other event
    always_comb begin
        next_state = state;
        case (state)
            txsc_pkg::TXSC_NONTX: begin
                if (op_begin) begin
                    next_state = txsc_pkg::TXSC_TX;
                end
            end
            txsc_pkg::TXSC_TX: begin
                if (fail || op_end) begin
                    next_state = txsc_pkg::TXSC_NONTX;
                end else if (intr_taken || op_suspres) begin
                    next_state = txsc_pkg::TXSC_SUSP;
                end
            end
            txsc_pkg::TXSC_SUSP: begin
                if (fail) begin
                    next_state = txsc_pkg::TXSC_NONTX;
                end else if (op_suspres) begin
                    next_state = txsc_pkg::TXSC_TX;
                end
            end
            default: begin
                next_state = txsc_pkg::TXSC_NONTX;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= txsc_pkg::TXSC_NONTX;
        end else begin
            state <= next_state;
        end
    end

    // Checkpoint, handler and mode captured at begin
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ckpt    <= '0;
            handler <= `TXSC_ADDR_RESET;
            rollback_only_txn     <= 1'b0;
        end else if (do_begin) begin
            ckpt    <= user_reg;
            handler <= handler_addr;
            rollback_only_txn     <= op_begin_rot;
        end
    end

    // Status word: cleared at begin, loaded on failure, otherwise held
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            txn_exception_status_reg <= `TXSC_TESR_RESET;
        end else if (fail) begin
            txn_exception_status_reg <= fail_status;
        end else if (do_begin) begin
            txn_exception_status_reg <= `TXSC_TESR_RESET;
        end
    end

    // Registered outputs toward memory, register file and fetch
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_state       <= 2'h0;
            store_tx_tag   <= 1'b0;
            commit_pulse   <= 1'b0;
            discard_pulse  <= 1'b0;
            restore_pulse  <= 1'b0;
            restore_val    <= '0;
            redirect_pulse <= 1'b0;
            redirect_addr  <= `TXSC_ADDR_RESET;
            barrier_pulse  <= 1'b0;
            rot_active     <= 1'b0;
            atomic_hold    <= 1'b0;
        end else begin
            tx_state       <= next_state;
            store_tx_tag   <= (next_state == txsc_pkg::TXSC_TX);
            commit_pulse   <= do_end;
            discard_pulse  <= fail;
            restore_pulse  <= fail;
            restore_val    <= ckpt;
            redirect_pulse <= fail;
            redirect_addr  <= handler;
            barrier_pulse  <= do_susp | do_resume | do_end | (in_tx & op_abort);
            rot_active     <= do_begin ? op_begin_rot : (rollback_only_txn & ~(fail | do_end));
            // Shared-storage atomicity only for full transactions
            atomic_hold    <= (next_state == txsc_pkg::TXSC_TX)
                              & ~(do_begin ? op_begin_rot : rollback_only_txn);
        end
    end
    // do_intr documents the interrupt path; it folds into the state decode
    wire unused_intr = do_intr;
endmodule
